// file: ctm_pkg.sv
// Package for the compact timer: register offsets, field positions, reset values, types
package ctm_pkg;

	// Register offsets on the plain register port (byte addresses)
	localparam logic [2:0] CTM_ADDR_CTRL0 = 3'h0;
	localparam logic [2:0] CTM_ADDR_CTRL1 = 3'h1;
	localparam logic [2:0] CTM_ADDR_CNT_LO = 3'h2;
	localparam logic [2:0] CTM_ADDR_CNT_HI = 3'h3;
	localparam logic [2:0] CTM_ADDR_CMPA_LO = 3'h4;
	localparam logic [2:0] CTM_ADDR_CMPA_HI = 3'h5;
	localparam logic [2:0] CTM_ADDR_FLAGS = 3'h6;

	// Reset values
	localparam logic [7:0] CTM_CTRL0_RST = 8'h00;
	localparam logic [7:0] CTM_CTRL1_RST = 8'h00;
	localparam logic [9:0] CTM_CNT_RST = 10'h000;
	localparam logic [9:0] CTM_CMPA_RST = 10'h000;

	// Counter geometry
	localparam int CTM_CNT_W = 10;
	localparam logic [9:0] CTM_CNT_MAX = 10'h3ff;

	// Mode select codes
	localparam logic [1:0] CTM_MODE_CMP = 2'h0;
	localparam logic [1:0] CTM_MODE_PWM = 2'h2;
	localparam logic [1:0] CTM_MODE_TMR = 2'h3;

	// Pin action codes
	localparam logic [1:0] CTM_ACT_NONE = 2'h0;
	localparam logic [1:0] CTM_ACT_LOW = 2'h1;
	localparam logic [1:0] CTM_ACT_HIGH = 2'h2;
	localparam logic [1:0] CTM_ACT_TOGGLE = 2'h3;
	localparam logic [1:0] CTM_ACT_PWM = 2'h2;

	// First control register: counter_on and period_compare_bits
	typedef struct packed {
		logic [3:0] rsvd;
		logic counter_on;
		logic [2:0] period_compare_bits;
	} ctm_ctrl0_t;

	// Second control register, bit 7 down to bit 0
	typedef struct packed {
		logic [1:0] mode_select;
		logic [1:0] pin_action_select;
		logic output_initial_level;
		logic output_invert;
		logic period_duty_swap;
		logic clear_source_select;
	} ctm_ctrl1_t;

	// Register port request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ctm_req_t;

endpackage

// file: ctm_timer.sv
// Compact 10-bit timer: control registers, counter, compare logic and output pin
//
// Notes on behaviour
// (R1) Period field matches counter bits nine to seven
// (R2) Clear source zero: period match clears counter
// (R3) Period field zero: counter runs to overflow
// (R4) Mode 00 compare, 10 PWM, 11 timer
// (R5) Software stops timer before changing mode
// (R6) Compare mode: none, low, high, toggle on A
// (R7) PWM: inactive, active, waveform by action code
// (R8) Timer mode: software leaves pin output disabled
// (R9) Counter-on rise restores initial pin level
// (R10) Requested level equal initial: no visible change
// (R11) Software changes PWM action only while off
// (R12) Initial level bit sets pre-match pin level
// (R13) PWM: initial level bit picks active level
// (R14) Invert bit inverts pin, not in timer mode
// (R15) Swap bit exchanges period and duty sources
// (R16) Clear source one: compare-A match clears counter
// (R17) Clear source ignored in PWM mode
// (R18) Counter read-only as low and high byte
// (R19) Compare-A readable and writable as two bytes
// (R20) Low write buffered, loaded on high write
// (R21) High read latches low byte into buffer
// (R22) Counter-on rise zeroes count, fall holds it
// (R23) Compare-A and period matches set own flags; the code sets the period flag only in PWM mode or with clear source zero
// (R24) Compare-A checks all ten counter bits
// (R25) All fields zero after reset
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module ctm_timer (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Register port
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// Timer clock tick (one-cycle enable from the clock selector, same domain)
	input wire logic i_tick,
	// Timer output pins
	output logic o_timer_out_pin_0,
	output logic o_timer_out_pin_1,
	output logic o_pin_oe,
	// Compare match event flags
	output logic o_match_a_flag,
	output logic o_period_match_flag
);

	typedef enum logic [2:0] {
		CTM_ST_OFF = 3'b001,
		CTM_ST_RUN = 3'b010,
		CTM_ST_START = 3'b100
	} ctm_state_t;

	ctm_pkg::ctm_req_t req;
	ctm_pkg::ctm_ctrl0_t ctrl0_r;
	ctm_pkg::ctm_ctrl1_t ctrl1_r;
	ctm_state_t state_r, state_nxt;
	logic [9:0] cnt_r, cnt_nxt;
	logic [9:0] cmpa_r;
	logic [7:0] wbuf_r;
	logic [7:0] rbuf_r;
	logic [7:0] rdata_r;
	logic pin_r, pin_nxt;
	logic flag_a_r, flag_p_r;
	logic on_d_r;
	logic on_rise;
	logic match_a, match_p, overflow;
	logic [9:0] cnt_inc;
	logic clr_cnt;
	logic pwm_active;
	logic pin_drive;

	// Address decode used by both the write and the read paths
	function automatic logic hit(input logic [2:0] a, input logic [2:0] ref_a, input logic s);
		hit = s && (a == ref_a);
	endfunction

	assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	// Control registers; reserved bits of the first stay zero
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ctrl0_r <= ctm_pkg::CTM_CTRL0_RST; // (R25)
			ctrl1_r <= ctm_pkg::CTM_CTRL1_RST; // (R25)
		end else begin
			if (hit(req.addr, ctm_pkg::CTM_ADDR_CTRL0, req.wr)) begin
				ctrl0_r <= {4'h0, req.wdata[3:0]};
			end
			if (hit(req.addr, ctm_pkg::CTM_ADDR_CTRL1, req.wr)) begin
				ctrl1_r <= req.wdata;
			end
		end
	end

	// Compare-A: low write parks in the buffer, high write commits both halves
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			wbuf_r <= 8'h00;
			cmpa_r <= ctm_pkg::CTM_CMPA_RST; // (R25)
		end else begin
			if (hit(req.addr, ctm_pkg::CTM_ADDR_CMPA_LO, req.wr)) begin
				wbuf_r <= req.wdata; // (R20)
			end
			if (hit(req.addr, ctm_pkg::CTM_ADDR_CMPA_HI, req.wr)) begin
				cmpa_r <= {req.wdata[1:0], wbuf_r}; // (R19) (R20)
			end
		end
	end

	// Counter-on edge detect; rise is seen in the same cycle the write lands in ctrl0_r
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			on_d_r <= 1'b0;
		end else begin
			on_d_r <= ctrl0_r.counter_on;
		end
	end
	assign on_rise = ctrl0_r.counter_on && !on_d_r;

	// Comparators look at the count the tick would reach, so a clear on match
	// gives a period of exactly the compare value, not one tick more
	assign cnt_inc = cnt_r + 10'h001;
	assign match_p = (ctrl0_r.period_compare_bits != 3'h0) &&
		(cnt_inc == {ctrl0_r.period_compare_bits, 7'h00}); // (R1)
	assign match_a = (cmpa_r != 10'h000) && (cnt_inc == cmpa_r); // (R24)
	assign overflow = (cnt_r == ctm_pkg::CTM_CNT_MAX);

	// Clear source: PWM uses the swap bit, other modes the clear select
	always_comb begin
		if (ctrl1_r.mode_select == ctm_pkg::CTM_MODE_PWM) begin
			// Period source chosen by swap; clear select has no say here
			if (ctrl1_r.period_duty_swap) begin // (R15) (R17)
				clr_cnt = match_a || overflow;
			end else begin
				clr_cnt = match_p || overflow;
			end
		end else if (ctrl1_r.clear_source_select) begin
			clr_cnt = match_a || overflow; // (R16)
		end else begin
			clr_cnt = match_p || overflow; // (R2) (R3)
		end
	end

	// Run state: off, starting (zero the count), running
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			CTM_ST_OFF: begin
				if (on_rise) begin
					state_nxt = CTM_ST_START;
				end
			end
			CTM_ST_START: begin
				state_nxt = ctrl0_r.counter_on ? CTM_ST_RUN : CTM_ST_OFF;
			end
			CTM_ST_RUN: begin
				if (!ctrl0_r.counter_on) begin
					state_nxt = CTM_ST_OFF;
				end
			end
			default: begin
				state_nxt = CTM_ST_OFF;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_r <= CTM_ST_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Counter next value; a clear wraps to zero on the same tick that matched
	always_comb begin
		cnt_nxt = cnt_r;
		if (state_r == CTM_ST_START) begin
			cnt_nxt = ctm_pkg::CTM_CNT_RST; // (R22)
		end else if (state_r == CTM_ST_RUN && i_tick) begin
			if (clr_cnt) begin
				cnt_nxt = ctm_pkg::CTM_CNT_RST;
			end else begin
				cnt_nxt = cnt_r + 10'h001;
			end
		end
	end

	// Off state holds the residual count
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			cnt_r <= ctm_pkg::CTM_CNT_RST; // (R25)
		end else begin
			cnt_r <= cnt_nxt; // (R22)
		end
	end

	// Match flags: period flag in PWM mode, otherwise only when the period compare is the clear source
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			flag_a_r <= 1'b0;
			flag_p_r <= 1'b0;
		end else begin
			flag_a_r <= (state_r == CTM_ST_RUN) && i_tick && match_a; // (R23)
			flag_p_r <= (state_r == CTM_ST_RUN) && i_tick && match_p &&
				(ctrl1_r.mode_select == ctm_pkg::CTM_MODE_PWM ||
				!ctrl1_r.clear_source_select); // (R23)
		end
	end

	// PWM duty comparison, chosen by the swap bit
	always_comb begin
		if (ctrl1_r.period_duty_swap) begin
			pwm_active = cnt_r[9:7] < ctrl0_r.period_compare_bits ||
				ctrl0_r.period_compare_bits == 3'h0; // (R15)
		end else begin
			pwm_active = cnt_r < cmpa_r; // (R15)
		end
	end

	// Pin level before the invert stage
	always_comb begin
		pin_nxt = pin_r;
		case (ctrl1_r.mode_select)
			ctm_pkg::CTM_MODE_CMP: begin
				if (on_rise) begin
					pin_nxt = ctrl1_r.output_initial_level; // (R9) (R12)
				end else if ((state_r == CTM_ST_RUN) && i_tick && match_a) begin
					// Setting a level the pin already holds leaves it unchanged
					case (ctrl1_r.pin_action_select) // (R6) (R10)
						ctm_pkg::CTM_ACT_LOW: pin_nxt = 1'b0;
						ctm_pkg::CTM_ACT_HIGH: pin_nxt = 1'b1;
						ctm_pkg::CTM_ACT_TOGGLE: pin_nxt = !pin_r;
						default: pin_nxt = pin_r;
					endcase
				end
			end
			ctm_pkg::CTM_MODE_PWM: begin
				// Active level follows the initial level bit
				case (ctrl1_r.pin_action_select) // (R7) (R13)
					ctm_pkg::CTM_ACT_NONE: pin_nxt = !ctrl1_r.output_initial_level;
					ctm_pkg::CTM_ACT_LOW: pin_nxt = ctrl1_r.output_initial_level;
					ctm_pkg::CTM_ACT_PWM: begin
						pin_nxt = (pwm_active && state_r == CTM_ST_RUN) ?
							ctrl1_r.output_initial_level : !ctrl1_r.output_initial_level;
					end
					default: pin_nxt = pin_r;
				endcase
			end
			default: begin
				pin_nxt = pin_r; // (R4) Timer mode and undefined code leave the pin alone
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pin_r <= 1'b0;
		end else begin
			pin_r <= pin_nxt;
		end
	end

	// Invert stage; timer mode does not drive the pin at all
	assign pin_drive = pin_nxt ^ (ctrl1_r.output_invert &&
		ctrl1_r.mode_select != ctm_pkg::CTM_MODE_TMR); // (R14)

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_timer_out_pin_0 <= 1'b0;
			o_timer_out_pin_1 <= 1'b0;
			o_pin_oe <= 1'b0;
		end else begin
			o_timer_out_pin_0 <= pin_drive;
			o_timer_out_pin_1 <= pin_drive;
			// Pin enable off in timer mode so the pin stays general purpose
			o_pin_oe <= ctrl1_r.mode_select == ctm_pkg::CTM_MODE_CMP ||
				ctrl1_r.mode_select == ctm_pkg::CTM_MODE_PWM; // (R8)
		end
	end

	assign o_match_a_flag = flag_a_r;
	assign o_period_match_flag = flag_p_r;

	// Read buffer: a high-byte read copies the matching low byte
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rbuf_r <= 8'h00;
		end else if (hit(req.addr, ctm_pkg::CTM_ADDR_CNT_HI, req.rd)) begin
			rbuf_r <= cnt_r[7:0]; // (R21)
		end else if (hit(req.addr, ctm_pkg::CTM_ADDR_CMPA_HI, req.rd)) begin
			rbuf_r <= cmpa_r[7:0]; // (R21)
		end
	end

	// Read data, valid the cycle after the strobe only
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rdata_r <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				ctm_pkg::CTM_ADDR_CTRL0: rdata_r <= ctrl0_r;
				ctm_pkg::CTM_ADDR_CTRL1: rdata_r <= ctrl1_r;
				ctm_pkg::CTM_ADDR_CNT_LO: rdata_r <= rbuf_r; // (R18) (R21)
				ctm_pkg::CTM_ADDR_CNT_HI: rdata_r <= {6'h00, cnt_r[9:8]}; // (R18)
				ctm_pkg::CTM_ADDR_CMPA_LO: rdata_r <= rbuf_r; // (R19) (R21)
				ctm_pkg::CTM_ADDR_CMPA_HI: rdata_r <= {6'h00, cmpa_r[9:8]}; // (R19)
				ctm_pkg::CTM_ADDR_FLAGS: rdata_r <= {6'h00, flag_p_r, flag_a_r};
				default: rdata_r <= 8'h00;
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	assign o_rdata = rdata_r;

endmodule

`default_nettype wire

// file: ctm_timer_chk.sv
// Port checker for the compact timer, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module ctm_timer_chk (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Register port
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	// Timer side
	input wire logic i_tick,
	input wire logic o_timer_out_pin_0,
	input wire logic o_timer_out_pin_1,
	input wire logic o_pin_oe,
	input wire logic o_match_a_flag,
	input wire logic o_period_match_flag
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	ctm_pkg::ctm_ctrl1_t c1_r;
	logic cmp_m;
	// Mirror of the mode register, built from the write strobes alone
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			c1_r <= ctm_pkg::CTM_CTRL1_RST;
		end else if (i_wr && i_addr == ctm_pkg::CTM_ADDR_CTRL1) begin
			c1_r <= i_wdata;
		end
	end
	assign cmp_m = c1_r.mode_select == ctm_pkg::CTM_MODE_CMP;
	// Four quiet cycles so a late pin update after a write is excused
	sequence quiet_none;
		(!i_wr && cmp_m && c1_r.pin_action_select == ctm_pkg::CTM_ACT_NONE)[*4];
	endsequence
	sequence clr_on_a;
		(cmp_m && c1_r.clear_source_select)[*3];
	endsequence
	rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data not idle");
	hi_zero_a: assert property ($past(i_rd) && $past(i_addr) inside {3'h3, 3'h5}
		|-> o_rdata[7:2] == 6'h00) else $error("high byte upper bits set");
	a_tick_a: assert property (o_match_a_flag |-> $past(i_tick))
		else $error("compare flag without tick");
	p_tick_a: assert property (o_period_match_flag |-> $past(i_tick))
		else $error("period flag without tick");
	a_pulse_a: assert property (o_match_a_flag |=> !o_match_a_flag)
		else $error("compare flag longer than a cycle");
	oe_cause_a: assert property ($changed(o_pin_oe) |-> $past(i_wr) || $past(i_wr, 2)
		|| $past(i_reset) || $past(i_reset, 2)) else $error("enable moved alone");
	tmr_oe_a: assert property ((c1_r.mode_select == ctm_pkg::CTM_MODE_TMR)[*3]
		|-> !o_pin_oe) else $error("enable high in timer mode");
	hold_pin_a: assert property (quiet_none |-> $stable(o_timer_out_pin_0))
		else $error("pin moved with no action");
	tog_pin_a: assert property (o_match_a_flag && cmp_m
		&& c1_r.pin_action_select == ctm_pkg::CTM_ACT_TOGGLE
		|-> ##[0:1] $changed(o_timer_out_pin_0)) else $error("pin did not toggle");
	no_pflag_a: assert property (clr_on_a |-> !o_period_match_flag)
		else $error("period flag while cleared by compare");
endmodule
bind ctm_timer ctm_timer_chk i_chk (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd,
	.o_rdata, .i_tick, .o_timer_out_pin_0, .o_timer_out_pin_1, .o_pin_oe,
	.o_match_a_flag, .o_period_match_flag);
`default_nettype wire

// file: ctm_timer_tb_top.sv
// Self-checking bench for the compact timer registers and pin
`timescale 1ns/1ps
`default_nettype none
module ctm_timer_tb_top;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [2:0] i_addr = 3'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_tick = 1'b0;
	logic [7:0] o_rdata;
	logic o_timer_out_pin_0;
	logic o_timer_out_pin_1;
	logic o_pin_oe;
	logic o_match_a_flag;
	logic o_period_match_flag;
	int err_total = 0;
	int tests_run = 0;
	int n;
	logic [7:0] v;
	// Period table: mode reg, control reg, flag chosen, expected gap
	logic [7:0] c1 [6] = '{8'h00, 8'h00, 8'h31, 8'ha9, 8'hab, 8'h00};
	logic [7:0] c0 [6] = '{8'h09, 8'h0f, 8'h09, 8'h09, 8'h09, 8'h08};
	int gx [6] = '{128, 896, 85, 128, 85, 1024};
	logic [5:0] sel = 6'h34;
	// Pin table: mode reg and expected {enable, pin}
	logic [7:0] pc [7] = '{8'h98, 8'h9c, 8'h88, 8'h80, 8'h08, 8'h0c, 8'hc8};
	logic [1:0] pe [7] = '{2'h3, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h0};
	// 125 MHz system clock
	always #4 i_clk = ~i_clk;
	ctm_timer i_dut (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_tick,
		.o_timer_out_pin_0, .o_timer_out_pin_1, .o_pin_oe, .o_match_a_flag,
		.o_period_match_flag);
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	// Data stands only in the cycle after the strobe, so sample that edge
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		chk(16'(o_rdata), 16'(e));
	endtask
	// Cycles to the next flag pulse; a lost pulse ends the run
	task automatic gap(input logic a_sel);
		n = 0;
		do begin
			@(negedge i_clk);
			n++;
			if (n > 2000) begin
				err_total++;
				$display("Error %0t: flag never came", $time);
				wrap_up();
			end
		end while ((a_sel ? o_match_a_flag : o_period_match_flag) !== 1'b1);
	endtask
	task automatic restart(input logic [7:0] m, input logic [7:0] c);
		wr(3'h0, 8'h00);
		wr(3'h1, m);
		wr(3'h0, c);
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge i_clk);
		i_reset <= 1'b0;
		for (int a = 0; a < 7; a++) rd(a[2:0], 8'h00);
		wr(3'h2, 8'hff);
		wr(3'h3, 8'h03);
		rd(3'h3, 8'h00);
		wr(3'h1, 8'h9e);
		rd(3'h1, 8'h9e);
		wr(3'h0, 8'hf5);
		rd(3'h0, 8'h05);
		wr(3'h4, 8'h34);
		wr(3'h5, 8'h02);
		rd(3'h5, 8'h02);
		rd(3'h4, 8'h34);
		wr(3'h4, 8'h55);
		rd(3'h5, 8'h02);
		rd(3'h4, 8'h34);
		wr(3'h5, 8'h00);
		rd(3'h5, 8'h00);
		rd(3'h4, 8'h55);
		// Exactly 300 ticks, then stop: the count must hold
		restart(8'h00, 8'h08);
		repeat (3) @(posedge i_clk);
		i_tick <= 1'b1;
		repeat (300) @(posedge i_clk);
		i_tick <= 1'b0;
		wr(3'h0, 8'h00);
		rd(3'h3, 8'h01);
		rd(3'h2, 8'h2c);
		wr(3'h0, 8'h08);
		repeat (3) @(posedge i_clk);
		rd(3'h3, 8'h00);
		rd(3'h2, 8'h00);
		i_tick <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			restart(c1[i], c0[i]);
			gap(sel[i]);
			gap(sel[i]);
			chk(16'(n), 16'(gx[i]));
		end
		// Toggle on each compare match from a low start
		restart(8'h31, 8'h09);
		repeat (2) @(posedge i_clk);
		chk(16'(o_timer_out_pin_0), 16'h0000);
		gap(1'b1);
		repeat (2) @(posedge i_clk);
		chk(16'(o_timer_out_pin_0), 16'h0001);
		gap(1'b1);
		repeat (2) @(posedge i_clk);
		chk(16'(o_timer_out_pin_0), 16'h0000);
		i_tick <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			restart(pc[i], 8'h08);
			repeat (4) @(posedge i_clk);
			chk(16'({o_pin_oe, o_pin_oe & o_timer_out_pin_0}), 16'(pe[i]));
		end
		wrap_up();
	end
endmodule
`default_nettype wire
